// ===== inc/echo_ctl_params.svh
// Constants of the echo canceller state control: offsets, fields, resets, timing.
`ifndef ECHO_CTL_PARAMS_SVH
`define ECHO_CTL_PARAMS_SVH
`define SYS_CLK_MHZ 200
`define TONE_ON_MS 1000
`define TONE_OFF_MS 400
`define TONE_ON_CYC (`TONE_ON_MS * 1000 * `SYS_CLK_MHZ)
`define TONE_OFF_CYC (`TONE_OFF_MS * 1000 * `SYS_CLK_MHZ)
`define REG_CTRL1_A 3'h0
`define REG_CTRL2_A 3'h1
`define REG_CTRL1_B 3'h2
`define REG_CTRL2_B 3'h3
`define REG_STAT_A 3'h4
`define REG_STAT_B 3'h5
`define REG_THRESH 3'h6
`define C1_CN_DIS 0
`define C1_MUTE_R 1
`define C1_MUTE_S 2
`define C1_BYPASS 3
`define C1_ADAPT_DIS 4
`define C1_B2B 5
`define C2_SUP_DIS 0
`define C2_PH_DIS 1
`define C2_AUTO_TD 2
`define C2_NB_DIS 3
`define C2_HPF_DIS 4
`define ST_TONE 0
`define ST_STATE_LO 1
`define ST_NLP 3
`define CTRL_RST 8'h00
`define THRESH_RST 16'h4000
`define QUIET_LIN 16'h0000
`define QUIET_SM 16'h0080
`define QUIET_MU 16'h00FF
`define QUIET_A 16'h00D5
`endif

// ===== inc/echo_ctl_pkg.sv
// Types shared by the echo canceller state control, the PCM sink and the bench.
package echo_ctl_pkg;
  // Gray codes along mute, bypass, disable adaptation, enable adaptation.
  typedef enum logic [1:0] {
    ST_MUTE = 2'h0,
    ST_BYPASS = 2'h1,
    ST_FROZEN = 2'h3,
    ST_ADAPT = 2'h2
  } fstate_t;
  typedef enum logic [1:0] {
    FMT_LINEAR = 2'h0,
    FMT_SIGNMAG = 2'h1,
    FMT_MULAW = 2'h2,
    FMT_ALAW = 2'h3
  } pcm_fmt_t;
  typedef struct packed {
    logic path_sout;
    logic canc_b;
    logic [15:0] raw;
    logic [15:0] cancelled;
  } sample_t;
  typedef struct packed {
    logic path_sout;
    logic canc_b;
    logic [15:0] data;
  } out_word_t;
  typedef struct packed {
    logic [7:0] sync1;
    logic [7:0] sync2;
    logic [1:0][7:0] ctrl1;
    logic [1:0][7:0] ctrl2;
    logic [15:0] thr;
    fstate_t [1:0] fst;
    logic [1:0] clr;
    logic [15:0] rdata;
    logic rvalid;
    out_word_t [1:0] fifo;
    logic wp;
    logic rp;
    logic [1:0] cnt;
  } top_state_t;
endpackage

// ===== rtl/echo_canceller_state_control.sv
// Control logic around a two-canceller voice echo canceller: states, suppression, tones, mute.
`timescale 1ns/1ps
`include "echo_ctl_params.svh"
// Notes on behaviour
// - Engage nonlinear processor when residual falls below the suppression threshold.
// - Inject comfort noise while the nonlinear processor is engaged.
// - Disable bit in control 2, or low strap in pin mode, disables suppression.
// - Threshold is a 16-bit fraction strictly between zero and one.
// - Comfort noise stops when its disable bit in control 1 is set.
// - Threshold and comfort noise act only while suppression is enabled.
// - Reversal-checking mode needs a one second tone with a phase reversal.
// - Plain mode needs only a one second tone within the level window.
// - Two detectors drive the active-low tone output of each canceller low.
// - Tone status stays latched until quiet persists for 400 ms.
// - Low reversal strap, or phase reversal disable bit, selects plain mode.
// - Automatic bit moves a canceller from enable adaptation to bypass on tone.
// - Tone outputs keep driving in controller mode as interrupt requests.
// - Narrowband tones halt adaptation unless the narrowband disable bit is set.
// - Offset filters run unless the offset filter disable bit is set.
// - Mute halts adaptation and outputs the quiet code of the format.
// - Mute A quiets receive out; in back-to-back mute B quiets send out.
// - Bypass passes input codes unchanged and clears coefficients on entry.
// - Disable adaptation freezes coefficients; enable adaptation updates them.
// - In pin mode each canceller's pin pair selects its state.
// - Controller mode with register access only when both config straps are low.
module echo_canceller_state_control #(
  parameter int TONE_ON_CYC = `TONE_ON_CYC,
  parameter int TONE_OFF_CYC = `TONE_OFF_CYC
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic config_strap_one,
  input wire logic config_strap_two,
  input wire logic reversal_strap,
  input wire logic suppressor_strap,
  input wire logic state_sel_a0,
  input wire logic state_sel_a1,
  input wire logic state_sel_b0,
  input wire logic state_sel_b1,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  input wire echo_ctl_pkg::pcm_fmt_t pcm_fmt,
  input wire logic [1:0] residual_below,
  input wire logic [3:0] tone_present,
  input wire logic [3:0] tone_reversal,
  input wire logic [3:0] band_quiet,
  input wire logic [1:0] narrowband_seen,
  input wire logic in_valid,
  output logic in_ready,
  input wire echo_ctl_pkg::sample_t in_sample,
  output logic out_valid,
  input wire logic out_ready,
  output echo_ctl_pkg::out_word_t out_sample,
  output logic tone_detect_n_a,
  output logic tone_detect_n_b,
  output logic controller_mode,
  output logic back_to_back,
  output logic [1:0] adapt_en,
  output logic [1:0] cancel_en,
  output logic [1:0] coef_clear,
  output logic [1:0] nonlinear_processor,
  output logic [1:0] comfort_noise_en,
  output logic [1:0] threshold_active,
  output logic [15:0] suppression_threshold,
  output logic [1:0] narrowband_detector_en,
  output logic [1:0] offset_filter_en,
  output echo_ctl_pkg::fstate_t [1:0] canceller_state
);
  echo_ctl_pkg::top_state_t st_ff, nxt_st;
  logic cm;
  logic g164;
  logic [3:0] det;
  logic [1:0] tone_found;
  logic [1:0] supp_en;
  logic [1:0] quiet_pair;
  logic [1:0] muted;
  logic push;
  logic pop;
  logic quiet_now;
  logic bypass_now;
  logic gov;
  logic [15:0] quiet_code;
  echo_ctl_pkg::fstate_t [1:0] want;

  // Mode straps come from pins: only the second sync stage is decoded.
  assign cm = !st_ff.sync2[0] && !st_ff.sync2[1];
  assign controller_mode = cm;
  assign back_to_back = cm ? st_ff.ctrl1[0][`C1_B2B] : (st_ff.sync2[0] && !st_ff.sync2[1]);
  // Plain detection applies to all four detectors at once.
  assign g164 = cm ? st_ff.ctrl2[0][`C2_PH_DIS] : !st_ff.sync2[2];

  // Release needs both inputs of a canceller quiet in both bands.
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_det
      tone_latch #(
        .ON_CYC(TONE_ON_CYC),
        .OFF_CYC(TONE_OFF_CYC)
      ) u_det (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .g164(g164),
        .tone_present(tone_present[gi]),
        .tone_reversal(tone_reversal[gi]),
        .quiet(quiet_pair[gi/2]),
        .detected(det[gi])
      );
    end
    for (gi = 0; gi < 2; gi++) begin : g_canc
      assign quiet_pair[gi] = band_quiet[2*gi] && band_quiet[2*gi+1];
      assign tone_found[gi] = det[2*gi] || det[2*gi+1];
      // Pin strap for suppression is shared; register bit is per canceller.
      assign supp_en[gi] = cm ? !st_ff.ctrl2[gi][`C2_SUP_DIS] : st_ff.sync2[3];
      assign nonlinear_processor[gi] = supp_en[gi] && residual_below[gi];
      assign comfort_noise_en[gi] = nonlinear_processor[gi]
        && !(cm && st_ff.ctrl1[gi][`C1_CN_DIS]);
      assign threshold_active[gi] = supp_en[gi];
      assign narrowband_detector_en[gi] = cm ? !st_ff.ctrl2[gi][`C2_NB_DIS] : 1'b1;
      assign offset_filter_en[gi] = cm ? !st_ff.ctrl2[gi][`C2_HPF_DIS] : 1'b1;
      // Coefficients move only in enable adaptation with no narrowband tone seen by an enabled detector.
      assign adapt_en[gi] = (st_ff.fst[gi] == echo_ctl_pkg::ST_ADAPT)
        && !(narrowband_detector_en[gi] && narrowband_seen[gi]);
      assign cancel_en[gi] = (st_ff.fst[gi] == echo_ctl_pkg::ST_ADAPT)
        || (st_ff.fst[gi] == echo_ctl_pkg::ST_FROZEN);
      assign muted[gi] = st_ff.fst[gi] == echo_ctl_pkg::ST_MUTE;
    end
  endgenerate

  // Open-drain style tone outputs keep driving in both modes.
  assign tone_detect_n_a = !tone_found[0];
  assign tone_detect_n_b = !tone_found[1];
  assign suppression_threshold = st_ff.thr;
  assign coef_clear = st_ff.clr;
  assign canceller_state = st_ff.fst;
  assign reg_rdata = st_ff.rdata;
  assign reg_rvalid = st_ff.rvalid;

  // Wanted state per canceller. Pin mode relies on the board wiring tone outputs to
  // the high select, so the device adds no tone logic of its own there.
  always_comb begin
    logic [1:0] pins;
    logic [7:0] c1;
    want = '{echo_ctl_pkg::ST_ADAPT, echo_ctl_pkg::ST_ADAPT};
    pins = 2'h0;
    c1 = 8'h00;
    for (int c = 0; c < 2; c++) begin
      if (cm) begin
        c1 = st_ff.ctrl1[c];
        if (c1[`C1_MUTE_R] || c1[`C1_MUTE_S]) want[c] = echo_ctl_pkg::ST_MUTE;
        else if (c1[`C1_BYPASS]) want[c] = echo_ctl_pkg::ST_BYPASS;
        else if (c1[`C1_ADAPT_DIS]) want[c] = echo_ctl_pkg::ST_FROZEN;
        else if (st_ff.ctrl2[c][`C2_AUTO_TD] && tone_found[c])
          want[c] = echo_ctl_pkg::ST_BYPASS;
        else want[c] = echo_ctl_pkg::ST_ADAPT;
      end else begin
        pins = (c == 0) ? st_ff.sync2[5:4] : st_ff.sync2[7:6];
        unique case (pins)
          2'h0: want[c] = echo_ctl_pkg::ST_MUTE;
          2'h1: want[c] = echo_ctl_pkg::ST_BYPASS;
          2'h2: want[c] = echo_ctl_pkg::ST_FROZEN;
          2'h3: want[c] = echo_ctl_pkg::ST_ADAPT;
        endcase
      end
    end
  end

  // Quiet code of the active format.
  always_comb begin
    unique case (pcm_fmt)
      echo_ctl_pkg::FMT_LINEAR: quiet_code = `QUIET_LIN;
      echo_ctl_pkg::FMT_SIGNMAG: quiet_code = `QUIET_SM;
      echo_ctl_pkg::FMT_MULAW: quiet_code = `QUIET_MU;
      echo_ctl_pkg::FMT_ALAW: quiet_code = `QUIET_A;
    endcase
  end

  // In back-to-back both cancellers serve one channel: A owns receive out, B send out.
  assign gov = back_to_back ? in_sample.path_sout : in_sample.canc_b;
  assign quiet_now = back_to_back ? muted[gov] : (!in_sample.path_sout && muted[gov]);
  assign bypass_now = st_ff.fst[gov] == echo_ctl_pkg::ST_BYPASS;

  // Two-entry buffer: a stalled receiver fills it and then holds the source.
  assign in_ready = st_ff.cnt != 2'h2;
  assign out_valid = st_ff.cnt != 2'h0;
  assign out_sample = st_ff.fifo[st_ff.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state: straps, registers, functional states, buffer and read data.
  always_comb begin
    nxt_st = st_ff;
    // First sync stage feeds only the second.
    nxt_st.sync1 = {state_sel_b1, state_sel_b0, state_sel_a1, state_sel_a0,
      suppressor_strap, reversal_strap, config_strap_two, config_strap_one};
    nxt_st.sync2 = st_ff.sync1;
    // Writes are honoured only in controller mode.
    if (reg_wr && cm) begin
      unique case (reg_addr)
        `REG_CTRL1_A: nxt_st.ctrl1[0] = reg_wdata[7:0];
        `REG_CTRL2_A: nxt_st.ctrl2[0] = reg_wdata[7:0];
        `REG_CTRL1_B: nxt_st.ctrl1[1] = reg_wdata[7:0];
        `REG_CTRL2_B: nxt_st.ctrl2[1] = reg_wdata[7:0];
        `REG_THRESH: begin
          // Zero or one-and-above is no valid fraction and is dropped.
          if (reg_wdata != 16'h0000 && !reg_wdata[15]) nxt_st.thr = reg_wdata;
        end
        default: ;
      endcase
    end
    nxt_st.rvalid = reg_rd;
    if (reg_rd) begin
      unique case (reg_addr)
        `REG_CTRL1_A: nxt_st.rdata = {8'h00, st_ff.ctrl1[0]};
        `REG_CTRL2_A: nxt_st.rdata = {8'h00, st_ff.ctrl2[0]};
        `REG_CTRL1_B: nxt_st.rdata = {8'h00, st_ff.ctrl1[1]};
        `REG_CTRL2_B: nxt_st.rdata = {8'h00, st_ff.ctrl2[1]};
        `REG_STAT_A: nxt_st.rdata = {12'h000, nonlinear_processor[0], st_ff.fst[0],
          tone_found[0]};
        `REG_STAT_B: nxt_st.rdata = {12'h000, nonlinear_processor[1], st_ff.fst[1],
          tone_found[1]};
        `REG_THRESH: nxt_st.rdata = st_ff.thr;
        default: nxt_st.rdata = 16'h0000;
      endcase
    end
    // Coefficient clear pulses once on each entry into bypass.
    for (int c = 0; c < 2; c++) begin
      nxt_st.fst[c] = want[c];
      nxt_st.clr[c] = (want[c] == echo_ctl_pkg::ST_BYPASS)
        && (st_ff.fst[c] != echo_ctl_pkg::ST_BYPASS);
    end
    if (push) begin
      nxt_st.fifo[st_ff.wp].path_sout = in_sample.path_sout;
      nxt_st.fifo[st_ff.wp].canc_b = in_sample.canc_b;
      if (quiet_now) nxt_st.fifo[st_ff.wp].data = quiet_code;
      else if (bypass_now) nxt_st.fifo[st_ff.wp].data = in_sample.raw;
      else nxt_st.fifo[st_ff.wp].data = in_sample.cancelled;
      nxt_st.wp = !st_ff.wp;
    end
    if (pop) nxt_st.rp = !st_ff.rp;
    nxt_st.cnt = 2'(st_ff.cnt + {1'b0, push} - {1'b0, pop});
  end

  // Reset gives default registers and enable adaptation; clock enable freezes all.
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_ff <= '0;
      st_ff.ctrl1 <= {`CTRL_RST, `CTRL_RST};
      st_ff.ctrl2 <= {`CTRL_RST, `CTRL_RST};
      st_ff.thr <= `THRESH_RST;
      st_ff.fst <= '{echo_ctl_pkg::ST_ADAPT, echo_ctl_pkg::ST_ADAPT};
    end else if (clk_en) begin
      st_ff <= nxt_st;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_thr_bad_write;
    clk_en && cm && reg_wr && reg_addr == `REG_THRESH && (reg_wdata == 16'h0000 || reg_wdata[15]);
  endsequence

  sequence s_mute_cmd;
    clk_en && cm && st_ff.ctrl1[0][`C1_MUTE_R];
  endsequence

  sequence s_auto_tone;
    clk_en && cm && st_ff.ctrl1[0][4:1] == 4'h0 && st_ff.ctrl2[0][`C2_AUTO_TD] && tone_found[0];
  endsequence

  a_nlp_gate: assert property (nonlinear_processor[0] |-> supp_en[0] && residual_below[0])
    else $error("suppression engaged while disabled or residual high");

  a_comfort_gate: assert property (comfort_noise_en[1] |-> nonlinear_processor[1]
    && !(cm && st_ff.ctrl1[1][`C1_CN_DIS]))
    else $error("comfort noise outside engaged suppression");

  a_thr_reject: assert property (s_thr_bad_write |=> $stable(suppression_threshold))
    else $error("invalid threshold fraction accepted");

  a_mute_wins: assert property (s_mute_cmd |=> canceller_state[0] == echo_ctl_pkg::ST_MUTE)
    else $error("mute lost priority");

  a_auto_bypass: assert property (s_auto_tone |=> canceller_state[0] == echo_ctl_pkg::ST_BYPASS)
    else $error("automatic tone bypass missing");

  a_pin_state: assert property (clk_en && !cm && st_ff.sync2[7:6] == 2'h2
    |=> canceller_state[1] == echo_ctl_pkg::ST_FROZEN)
    else $error("pin pair state select wrong");

  a_clear_entry: assert property (clk_en && coef_clear[0] |-> canceller_state[0]
    == echo_ctl_pkg::ST_BYPASS ##1 !coef_clear[0] || !clk_en)
    else $error("coefficient clear not a single pulse on bypass entry");

  a_adapt_halt: assert property (adapt_en[1] |->
    canceller_state[1] == echo_ctl_pkg::ST_ADAPT
    && !(narrowband_detector_en[1] && narrowband_seen[1]))
    else $error("adaptation while halted");

  a_tone_pin: assert property (det[2] |-> !tone_detect_n_b)
    else $error("tone output not driven low on detection");

  a_quiet_out: assert property (clk_en && push && quiet_now
    && pcm_fmt == echo_ctl_pkg::FMT_ALAW
    |=> st_ff.fifo[$past(st_ff.wp)].data == 16'h00D5)
    else $error("quiet code wrong");

  // These guard the buffer, the bypass path and adaptation in mute.
  a_buf_bound: assert property (st_ff.cnt != 2'h3)
    else $error("buffer count beyond two");

  a_bypass_raw: assert property (clk_en && push && !quiet_now && bypass_now
    |=> st_ff.fifo[$past(st_ff.wp)].data == $past(in_sample.raw))
    else $error("bypass word altered");

  a_mute_halt: assert property (muted[0] |-> !adapt_en[0])
    else $error("adaptation in mute");

  // These guard pin mode and the status word.
  a_pin_plain: assert property (!cm && !st_ff.sync2[2] |-> g164)
    else $error("reversal check kept with strap low");

  a_pin_no_write: assert property (clk_en && !cm && reg_wr
    |=> $stable(st_ff.ctrl1)
    && $stable(st_ff.ctrl2)
    && $stable(st_ff.thr))
    else $error("register written in pin mode");

  a_stat_tone: assert property (clk_en && reg_rd
    && reg_addr == `REG_STAT_A
    |=> reg_rvalid
    && reg_rdata[0] == $past(tone_found[0]))
    else $error("status read lost the tone flag");
endmodule // echo_canceller_state_control

// ===== rtl/tone_latch.sv
// One disable-tone detector: duration qualification, reversal check and latched status.
`timescale 1ns/1ps
`include "echo_ctl_params.svh"
module tone_latch #(
  parameter int ON_CYC = `TONE_ON_CYC,
  parameter int OFF_CYC = `TONE_OFF_CYC,
  parameter int CW = 28
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic g164,
  input wire logic tone_present,
  input wire logic tone_reversal,
  input wire logic quiet,
  output logic detected
);
  typedef struct packed {
    logic [CW-1:0] run;
    logic rev_seen;
    logic latched;
    logic [CW-1:0] qcnt;
  } det_state_t;
  det_state_t st_ff, nxt_st;
  logic trigger;

  // Release first, then trigger, so a fresh tone wins over a release in the same cycle.
  always_comb begin
    nxt_st = st_ff;
    trigger = 1'b0;
    if (tone_present) begin
      if (st_ff.run != CW'(ON_CYC - 1)) nxt_st.run = CW'(st_ff.run + 1'b1);
      nxt_st.rev_seen = st_ff.rev_seen | tone_reversal;
      trigger = (st_ff.run == CW'(ON_CYC - 1)) && (g164 || st_ff.rev_seen);
    end else begin
      nxt_st.run = '0;
      nxt_st.rev_seen = 1'b0;
    end
    if (st_ff.latched && quiet) begin
      nxt_st.qcnt = CW'(st_ff.qcnt + 1'b1);
      if (st_ff.qcnt == CW'(OFF_CYC - 1)) begin
        nxt_st.latched = 1'b0;
        nxt_st.qcnt = '0;
      end
    end else begin
      nxt_st.qcnt = '0;
    end
    if (trigger) nxt_st.latched = 1'b1;
  end

  // State freezes while the clock enable is low.
  always_ff @(posedge sys_clk) begin
    if (rst) st_ff <= '0;
    else if (clk_en) st_ff <= nxt_st;
  end

  assign detected = st_ff.latched;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  sequence s_loud_latched;
    st_ff.latched && !quiet && clk_en;
  endsequence
  a_latch_holds: assert property (s_loud_latched |=> st_ff.latched)
    else $error("tone status released while band energy present");
  a_trigger_cause: assert property ($rose(st_ff.latched) |->
    $past(st_ff.run) == CW'(ON_CYC - 1) && $past(g164 || st_ff.rev_seen))
    else $error("tone status set without full duration or reversal");
endmodule // tone_latch

// ===== verif/pcm_sink.sv
// Far-side PCM sink that can stall and records every word it takes.
`timescale 1ns/1ps
module pcm_sink (
  input wire logic sys_clk,
  input wire logic stall,
  input wire logic out_valid,
  output logic out_ready,
  input wire echo_ctl_pkg::out_word_t out_sample
);
  logic [15:0] q[$];
  // Ready moves only at the falling edge, so the design always samples it settled.
  initial begin
    out_ready = 1'b0;
  end
  always @(negedge sys_clk) begin
    out_ready <= !stall;
  end
  // A word is delivered at the rising edge where both sides agree.
  always @(posedge sys_clk) begin
    if (out_valid && out_ready) begin
      q.push_back(out_sample.data);
    end
  end
endmodule // pcm_sink

// ===== verif/tb.sv
// Self-checking bench for the echo canceller state control.
`timescale 1ns/1ps
`include "echo_ctl_params.svh"
module tb;
  logic sys_clk, rst, clk_en, config_strap_one, config_strap_two, reversal_strap;
  logic suppressor_strap, state_sel_a0, state_sel_a1, state_sel_b0, state_sel_b1;
  logic reg_wr, reg_rd, reg_rvalid, in_valid, in_ready, out_valid, out_ready, stall;
  logic tone_detect_n_a, tone_detect_n_b, controller_mode, back_to_back;
  logic [2:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, suppression_threshold, d;
  logic [1:0] residual_below, narrowband_seen, adapt_en, cancel_en, coef_clear;
  logic [1:0] nonlinear_processor, comfort_noise_en, threshold_active;
  logic [1:0] narrowband_detector_en, offset_filter_en;
  logic [3:0] tone_present, tone_reversal, band_quiet;
  echo_ctl_pkg::pcm_fmt_t pcm_fmt;
  echo_ctl_pkg::sample_t in_sample;
  echo_ctl_pkg::out_word_t out_sample;
  echo_ctl_pkg::fstate_t [1:0] canceller_state;
  int failures = 0, checked = 0, clears = 0;
  logic [15:0] cv[4] = '{16'h000A, 16'h0018, 16'h0010, 16'h0000};
  logic [15:0] qc[4] = '{`QUIET_LIN, `QUIET_SM, `QUIET_MU, `QUIET_A};
  logic [1:0] pri[4] = '{2'h0, 2'h1, 2'h3, 2'h2};
  logic [1:0] pin[4] = '{2'h0, 2'h1, 2'h3, 2'h2};

  // Short tone counts keep the run brief; expectations use the same figures.
  echo_canceller_state_control #(.TONE_ON_CYC(20), .TONE_OFF_CYC(8)) dut (
    .sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .config_strap_one(config_strap_one),
    .config_strap_two(config_strap_two), .reversal_strap(reversal_strap),
    .suppressor_strap(suppressor_strap), .state_sel_a0(state_sel_a0),
    .state_sel_a1(state_sel_a1), .state_sel_b0(state_sel_b0), .state_sel_b1(state_sel_b1),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .pcm_fmt(pcm_fmt),
    .residual_below(residual_below), .tone_present(tone_present),
    .tone_reversal(tone_reversal), .band_quiet(band_quiet), .narrowband_seen(narrowband_seen),
    .in_valid(in_valid), .in_ready(in_ready), .in_sample(in_sample), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample), .tone_detect_n_a(tone_detect_n_a),
    .tone_detect_n_b(tone_detect_n_b), .controller_mode(controller_mode),
    .back_to_back(back_to_back), .adapt_en(adapt_en), .cancel_en(cancel_en),
    .coef_clear(coef_clear), .nonlinear_processor(nonlinear_processor),
    .comfort_noise_en(comfort_noise_en), .threshold_active(threshold_active),
    .suppression_threshold(suppression_threshold),
    .narrowband_detector_en(narrowband_detector_en), .offset_filter_en(offset_filter_en),
    .canceller_state(canceller_state));

  pcm_sink sink (.sys_clk(sys_clk), .stall(stall), .out_valid(out_valid),
    .out_ready(out_ready), .out_sample(out_sample));

  // Clock at 200 MHz.
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // Counts canceller A's coefficient clear pulses, which last a single cycle.
  always @(posedge sys_clk) begin
    if (coef_clear[0] === 1'b1) clears++;
  end

  task automatic summarize();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  // Write holds its request for one enabled edge, then lets the state settle.
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    @(negedge sys_clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge sys_clk);
    reg_wr = 1'b0;
    repeat (2) @(negedge sys_clk);
  endtask

  // The answer is looked at in the one cycle where the valid pulse stands.
  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    int i;
    @(negedge sys_clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge sys_clk);
    reg_rd = 1'b0;
    v = 16'hXXXX;
    for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) @(negedge sys_clk);
    if (reg_rvalid === 1'b1) v = reg_rdata;
  endtask

  task automatic send(input logic ps, input logic cb);
    int i;
    @(negedge sys_clk);
    in_sample = '{ps, cb, 16'h1234, 16'h5678};
    in_valid = 1'b1;
    for (i = 0; i < 20 && in_ready !== 1'b1; i++) @(negedge sys_clk);
    @(negedge sys_clk);
    in_valid = 1'b0;
  endtask

  task automatic take(input logic [15:0] exp, input string msg);
    logic [15:0] w;
    repeat (3) @(negedge sys_clk);
    w = (sink.q.size() > 0) ? sink.q.pop_front() : 16'hXXXX;
    chk(w, exp, msg);
  endtask

  // Watchdog: the tests need well under two thousand cycles.
  initial begin
    repeat (20000) @(posedge sys_clk);
    failures++;
    summarize();
  end

  initial begin
    {rst, clk_en, config_strap_one, config_strap_two, reversal_strap} = 5'h19;
    {suppressor_strap, state_sel_a0, state_sel_a1, state_sel_b0, state_sel_b1} = 5'h1F;
    {reg_wr, reg_rd, reg_addr, reg_wdata, in_valid, stall} = '0;
    {residual_below, narrowband_seen, tone_present, tone_reversal, band_quiet} = 16'hC000;
    pcm_fmt = echo_ctl_pkg::FMT_LINEAR;
    in_sample = '0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    rd(`REG_THRESH, d);
    chk(d, `THRESH_RST, "threshold reset");
    rd(`REG_CTRL1_A, d);
    chk(d, {8'h00, `CTRL_RST}, "control reset");
    wr(`REG_THRESH, 16'h0000);
    wr(`REG_THRESH, 16'h8000);
    wr(`REG_THRESH, 16'h4800);
    rd(`REG_THRESH, d);
    chk(d, 16'h4800, "threshold fraction only");
    chk(suppression_threshold, 16'h4800, "threshold output");
    rd(3'h7, d);
    chk(d, 16'h0000, "unmapped read");
    chk(nonlinear_processor, 2'h3, "suppressor engaged");
    chk(comfort_noise_en, 2'h3, "comfort noise on");
    wr(`REG_CTRL1_A, 16'h0001);
    chk(comfort_noise_en, 2'h2, "comfort noise off");
    wr(`REG_CTRL2_A, 16'h0019);
    wr(`REG_CTRL1_A, 16'h0000);
    chk(nonlinear_processor, 2'h2, "suppressor disabled");
    chk({threshold_active, comfort_noise_en}, 4'hA, "no threshold or noise");
    chk(narrowband_detector_en, 2'h2, "narrowband off");
    chk(offset_filter_en, 2'h2, "offset filter off");
    wr(`REG_CTRL2_A, 16'h0000);
    $display("test suppression done");
    for (int i = 0; i < 4; i++) begin
      wr(`REG_CTRL1_A, cv[i]);
      chk(canceller_state[0], pri[i], "state priority");
      chk(adapt_en[0], (i == 3), "adaptation enable");
      chk(cancel_en[0], (i >= 2), "cancelling");
    end
    chk(clears, 1, "clear on bypass entry");
    $display("test states done");
    wr(`REG_CTRL1_A, 16'h0002);
    for (int f = 0; f < 4; f++) begin
      pcm_fmt = echo_ctl_pkg::pcm_fmt_t'(f);
      send(1'b0, 1'b0);
      take(qc[f], "quiet code");
    end
    send(1'b1, 1'b0);
    take(16'h5678, "send path not quieted");
    wr(`REG_CTRL1_A, 16'h0008);
    send(1'b0, 1'b0);
    take(16'h1234, "bypass raw");
    wr(`REG_CTRL1_A, 16'h0020);
    wr(`REG_CTRL1_B, 16'h0002);
    chk(back_to_back, 1'b1, "back to back");
    send(1'b1, 1'b0);
    take(`QUIET_A, "mute B quiets send");
    wr(`REG_CTRL1_A, 16'h0000);
    wr(`REG_CTRL1_B, 16'h0000);
    stall = 1'b1;
    @(negedge sys_clk);
    send(1'b0, 1'b0);
    send(1'b0, 1'b1);
    chk(in_ready, 1'b0, "buffer full");
    chk(out_valid, 1'b1, "words held");
    stall = 1'b0;
    take(16'h5678, "first held word");
    take(16'h5678, "second held word");
    $display("test stream done");
    wr(`REG_CTRL2_A, 16'h0004);
    tone_present[0] = 1'b1;
    repeat (30) @(negedge sys_clk);
    chk(tone_detect_n_a, 1'b1, "no trigger without reversal");
    tone_reversal[0] = 1'b1;
    @(negedge sys_clk);
    tone_reversal[0] = 1'b0;
    repeat (25) @(negedge sys_clk);
    chk(tone_detect_n_a, 1'b0, "tone detected");
    chk(canceller_state[0], echo_ctl_pkg::ST_BYPASS, "automatic bypass");
    rd(`REG_STAT_A, d);
    chk(d[0], 1'b1, "tone flag");
    tone_present[0] = 1'b0;
    repeat (12) @(negedge sys_clk);
    chk(tone_detect_n_a, 1'b0, "latched");
    band_quiet = 4'h3;
    repeat (12) @(negedge sys_clk);
    chk(tone_detect_n_a, 1'b1, "released");
    wr(`REG_CTRL2_A, 16'h0002);
    tone_present[2] = 1'b1;
    repeat (30) @(negedge sys_clk);
    chk(tone_detect_n_b, 1'b0, "plain mode trigger");
    $display("test tones done");
    {config_strap_one, config_strap_two} = 2'h3;
    repeat (5) @(negedge sys_clk);
    chk(controller_mode, 1'b0, "pin mode");
    wr(`REG_THRESH, 16'h1000);
    for (int i = 0; i < 4; i++) begin
      {state_sel_b1, state_sel_b0, state_sel_a1, state_sel_a0} = {2{i[1:0]}};
      repeat (5) @(negedge sys_clk);
      chk(canceller_state[0], pin[i], "pin state");
      chk(canceller_state[1], pin[i], "pin state b");
    end
    suppressor_strap = 1'b0;
    {state_sel_b1, state_sel_b0} = {tone_detect_n_b, 1'b1};
    repeat (5) @(negedge sys_clk);
    chk(nonlinear_processor, 2'h0, "strap disables suppressor");
    chk(canceller_state[1], echo_ctl_pkg::ST_BYPASS, "tone routed to select");
    {config_strap_one, config_strap_two} = 2'h0;
    repeat (5) @(negedge sys_clk);
    rd(`REG_THRESH, d);
    chk(d, 16'h4800, "pin mode write ignored");
    $display("test pins done");
    summarize();
  end
endmodule // tb
